//--- hdl/elg_core.sv
// Fetch, decode and execute core for the eight-bit transfer_op group
// Notes on behaviour
// RQ1 - Register copy takes one 4-clock machine cycle; flags untouched.
// RQ2 - Register fields: A=111, B=000, C=001, D=010, E=011, H=100, L=101.
// RQ3 - Immediate register load uses the next byte; cycles of 4 and 3.
// RQ4 - Load from pointer_pair address into register; cycles of 4 and 3.
// RQ5 - DD prefix: load from index_reg_first plus displacement; 19 clocks.
// RQ6 - FD prefix: load from index_reg_second plus displacement; 4,4,3,5,3.
// RQ7 - Store register to pointer_pair address; cycles of 4 and 3.
// RQ8 - DD prefix: store to index_reg_first plus displacement; 4,4,3,5,3.
// RQ9 - FD prefix: store to index_reg_second plus displacement; 19 clocks.
// RQ10 - Opcode 36 unprefixed stores immediate byte at pointer_pair; 4,3,3.
// RQ11 - One T state per clock; first machine cycle lasts four clocks.
// RQ12 - Field value 110 means memory operand, not a register.
// RQ13 - Prefixed forms reuse unprefixed layout; displacement is third byte.
`include "elg_regs.svh"

module elg_core
  import elg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  input  wire logic              ce_in,
  // Memory bus
  input  wire logic [7:0]        mem_rdata_in,
  output elg_bus_t               mem_req_out,
  // Index registers held elsewhere in the processor
  input  wire logic [15:0]       index_reg_first_in,
  input  wire logic [15:0]       index_reg_second_in,
  // Architectural state and status
  output logic [7:0][7:0]        regs_out,
  output logic [15:0]            pc_out,
  output elg_status_t            status_out
);

  elg_state_t        state_q, state_d;
  elg_pfx_t          pfx_q, pfx_d;
  logic [2:0]        t_q, t_d;
  logic [7:0]        op_q, op_d;
  logic [15:0]       ea_q, ea_d;
  logic [15:0]       pc_q, pc_d;
  logic [7:0][7:0]   regs_q, regs_d;
  elg_bus_t          bus_q, bus_d;
  elg_status_t       stat_q, stat_d;

  logic [2:0]        cyc_len;
  logic              last_t;
  logic [2:0]        fdst;
  logic [2:0]        fsrc;
  logic [1:0]        fgrp;
  logic [2:0]        odst;
  logic [2:0]        osrc;
  logic [15:0]       pointer_pair;
  logic [15:0]       idx_base;
  logic [15:0]       disp_ext;
  // Single register write port, applied per entry below
  logic              wr_en;
  logic [2:0]        wr_sel;
  logic [7:0]        wr_data;

  assign fdst         = mem_rdata_in[`ELG_DST_HI:`ELG_DST_LO];
  assign fsrc         = mem_rdata_in[`ELG_SRC_HI:`ELG_SRC_LO];
  assign fgrp         = mem_rdata_in[`ELG_GRP_HI:`ELG_GRP_LO];
  assign odst         = op_q[`ELG_DST_HI:`ELG_DST_LO];
  assign osrc         = op_q[`ELG_SRC_HI:`ELG_SRC_LO];
  assign pointer_pair = {regs_q[`ELG_FLD_H], regs_q[`ELG_FLD_L]};
  assign idx_base     = (pfx_q == ELG_PFX_IDX2) ? index_reg_second_in
                                                : index_reg_first_in;
  // Displacement byte is two's complement
  assign disp_ext     = {{8{mem_rdata_in[7]}}, mem_rdata_in};

  // RQ11 machine cycle lengths
  always_comb
  begin
    case (state_q)
      ELG_ST_FETCH: cyc_len = `ELG_T_FETCH;
      ELG_ST_ADDR:  cyc_len = `ELG_T_ADDR;
      default:      cyc_len = `ELG_T_MEM;
    endcase
  end

  // t_q counts T states from zero within each machine cycle
  assign last_t = (t_q == cyc_len - 3'h1);

  // Register file entries; field 110 is memory, so entry 6 never loads
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_reg
    assign regs_d[gi] = (wr_en && wr_sel == 3'(gi)) ? wr_data : regs_q[gi];
  end

  // Sequencer and datapath next values
  always_comb
  begin
    state_d = state_q;
    pfx_d   = pfx_q;
    t_d     = last_t ? 3'h0 : t_q + 3'h1;
    op_d    = op_q;
    ea_d    = ea_q;
    pc_d    = pc_q;
    wr_en   = 1'b0;
    wr_sel  = 3'h0;
    wr_data = 8'h00;
    stat_d  = '0;
    if (last_t)
    begin
      case (state_q)
        ELG_ST_FETCH:
        begin
          pc_d  = pc_q + 16'h0001;
          op_d  = mem_rdata_in;
          state_d = ELG_ST_FETCH;
          pfx_d   = ELG_PFX_NONE;
          // A prefix is a whole fetch of its own but raises no done
          // RQ5 first prefix recognised
          if (mem_rdata_in == `ELG_PFX_FIRST)
          begin
            pfx_d = ELG_PFX_IDX1;
          end
          // RQ6 second prefix recognised
          else if (mem_rdata_in == `ELG_PFX_SECOND)
          begin
            pfx_d = ELG_PFX_IDX2;
          end
          else if (fgrp == `ELG_GRP_COPY && mem_rdata_in != `ELG_OP_HALT)
          begin
            // RQ12 memory field selects memory forms
            if (fsrc == `ELG_FLD_MEM || fdst == `ELG_FLD_MEM)
            begin
              pfx_d = pfx_q;
              if (pfx_q != ELG_PFX_NONE)
              begin
                // RQ13 displacement follows the opcode
                state_d = ELG_ST_DISP;
              end
              else
              begin
                // RQ4 RQ7 address from pointer pair
                ea_d    = pointer_pair;
                state_d = (fsrc == `ELG_FLD_MEM) ? ELG_ST_MRD : ELG_ST_MWR;
              end
            end
            else if (pfx_q == ELG_PFX_NONE)
            begin
              // RQ1 RQ2 register copy, flags untouched
              wr_en          = 1'b1;
              wr_sel         = fdst;
              wr_data        = regs_q[fsrc];
              stat_d.done    = 1'b1;
            end
            else
            begin
              stat_d.unsupported = 1'b1;
              stat_d.done        = 1'b1;
            end
          end
          else if (fgrp == `ELG_GRP_IMM && fsrc == `ELG_FLD_MEM &&
                   (pfx_q == ELG_PFX_NONE || fdst != `ELG_FLD_MEM))
          begin
            // RQ3 RQ10 immediate byte follows
            ea_d    = pointer_pair;
            state_d = ELG_ST_IMM;
          end
          else
          begin
            // Anything outside the group completes as a no-op
            stat_d.unsupported = 1'b1;
            stat_d.done        = 1'b1;
          end
        end
        ELG_ST_IMM:
        begin
          pc_d = pc_q + 16'h0001;
          if (op_q == `ELG_OP_IMM_MEM)
          begin
            // RQ10 immediate byte written to pointer pair address
            op_d    = mem_rdata_in;
            state_d = ELG_ST_MWR;
          end
          else
          begin
            // RQ3 immediate into register
            wr_en        = 1'b1;
            wr_sel       = odst;
            wr_data      = mem_rdata_in;
            stat_d.done  = 1'b1;
            state_d      = ELG_ST_FETCH;
          end
        end
        ELG_ST_DISP:
        begin
          // RQ5 RQ6 RQ8 RQ9 index plus sign-extended displacement
          pc_d    = pc_q + 16'h0001;
          ea_d    = idx_base + disp_ext;
          state_d = ELG_ST_ADDR;
        end
        ELG_ST_ADDR:
        begin
          // Five idle clocks give the address sum time before the access
          state_d = (osrc == `ELG_FLD_MEM) ? ELG_ST_MRD : ELG_ST_MWR;
        end
        ELG_ST_MRD:
        begin
          // RQ4 RQ5 RQ6 memory byte into register
          wr_en        = 1'b1;
          wr_sel       = odst;
          wr_data      = mem_rdata_in;
          stat_d.done  = 1'b1;
          pfx_d        = ELG_PFX_NONE;
          state_d      = ELG_ST_FETCH;
        end
        ELG_ST_MWR:
        begin
          stat_d.done = 1'b1;
          pfx_d       = ELG_PFX_NONE;
          state_d     = ELG_ST_FETCH;
        end
        default:
        begin
          pfx_d   = ELG_PFX_NONE;
          state_d = ELG_ST_FETCH;
        end
      endcase
    end
  end

  // Bus request for the machine cycle being entered; held for all of it
  always_comb
  begin
    bus_d       = bus_q;
    if (last_t)
    begin
      bus_d.rd    = 1'b0;
      bus_d.wr    = 1'b0;
      bus_d.addr  = pc_d;
      case (state_d)
        ELG_ST_FETCH,
        ELG_ST_IMM,
        ELG_ST_DISP:
        begin
          bus_d.rd = 1'b1;
        end
        ELG_ST_MRD:
        begin
          bus_d.rd   = 1'b1;
          bus_d.addr = ea_d;
        end
        ELG_ST_MWR:
        begin
          // RQ7 RQ8 RQ9 RQ10 store data and address
          bus_d.wr    = 1'b1;
          bus_d.addr  = ea_d;
          bus_d.wdata = (state_q == ELG_ST_IMM) ? mem_rdata_in
                                                : regs_q[osrc];
        end
        default:
        begin
          // Address add cycle: no strobe, address parked on the sum
          bus_d.addr = ea_d;
        end
      endcase
      if (state_q == ELG_ST_FETCH && state_d == ELG_ST_MWR)
      begin
        bus_d.wdata = regs_q[fsrc];
      end
    end
  end

  // Register stage; clock enable freezes everything
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= ELG_ST_FETCH;
      pfx_q   <= ELG_PFX_NONE;
      t_q     <= 3'h0;
      op_q    <= 8'h00;
      ea_q    <= 16'h0000;
      pc_q    <= `ELG_PC_RESET;
      regs_q  <= {8{`ELG_REG_RESET}};
      // Reset parks the bus on the opcode fetch at the reset address
      bus_q   <= '{addr: `ELG_PC_RESET, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      stat_q  <= '0;
    end
    else if (ce_in)
    begin
      state_q <= state_d;
      pfx_q   <= pfx_d;
      t_q     <= t_d;
      op_q    <= op_d;
      ea_q    <= ea_d;
      pc_q    <= pc_d;
      regs_q  <= regs_d;
      bus_q   <= bus_d;
      stat_q  <= stat_d;
    end
  end

  assign mem_req_out = bus_q;
  assign regs_out    = regs_q;
  assign pc_out      = pc_q;
  assign status_out  = stat_q;

endmodule // elg_core

//--- hdl/elg_regs.svh
// Encodings, field positions, cycle lengths and reset values
`ifndef ELG_REGS_SVH
`define ELG_REGS_SVH
`define ELG_T_FETCH     3'h4
`define ELG_T_MEM       3'h3
`define ELG_T_ADDR      3'h5
`define ELG_PFX_FIRST   8'hdd
`define ELG_PFX_SECOND  8'hfd
`define ELG_OP_IMM_MEM  8'h36
`define ELG_OP_HALT     8'h76
`define ELG_GRP_HI      7
`define ELG_GRP_LO      6
`define ELG_DST_HI      5
`define ELG_DST_LO      3
`define ELG_SRC_HI      2
`define ELG_SRC_LO      0
`define ELG_GRP_COPY    2'h1
`define ELG_GRP_IMM     2'h0
`define ELG_FLD_MEM     3'h6
`define ELG_FLD_H       3'h4
`define ELG_FLD_L       3'h5
`define ELG_PC_RESET    16'h0000
`define ELG_REG_RESET   8'h00
`endif

//--- hdl/elg_pkg.sv
// Types shared by the eight-bit transfer group core
package elg_pkg;
  typedef enum logic [2:0] {
    ELG_ST_FETCH,
    ELG_ST_IMM,
    ELG_ST_DISP,
    ELG_ST_ADDR,
    ELG_ST_MRD,
    ELG_ST_MWR
  } elg_state_t;

  typedef enum logic [1:0] {
    ELG_PFX_NONE,
    ELG_PFX_IDX1,
    ELG_PFX_IDX2
  } elg_pfx_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } elg_bus_t;

  typedef struct packed {
    logic done;
    logic unsupported;
  } elg_status_t;
endpackage

//--- verification/elg_core_props.sv
// Checker on the transfer group core ports
module elg_core_props
  import elg_pkg::*;
(
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        reset_in,
  // Observed outputs
  input elg_bus_t         mem_req_out,
  input logic [7:0][7:0]  regs_out,
  input elg_status_t      status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_done_one_pulse: assert property (
    status_out.done |=> !status_out.done) else $error("done too long");
  a_fetch_four: assert property (
    status_out.done |-> mem_req_out.rd [*4]) else $error("short fetch");
  a_req_holds: assert property (
    $changed(mem_req_out) |=> $stable(mem_req_out) [*2])
    else $error("machine cycle under three clocks");
  a_rd_wr_apart: assert property (
    !(mem_req_out.rd && mem_req_out.wr)) else $error("read and write");
  a_write_three: assert property (
    $rose(mem_req_out.wr) |-> mem_req_out.wr [*3] ##1
    (mem_req_out.rd && !mem_req_out.wr)) else $error("bad write cycle");
  a_idle_five: assert property (
    $fell(mem_req_out.rd) && !mem_req_out.wr |->
    (!mem_req_out.rd && !mem_req_out.wr) [*5] ##1
    (mem_req_out.rd || mem_req_out.wr)) else $error("bad address cycle");
  a_regs_at_end: assert property (
    $changed(regs_out) |-> status_out.done) else $error("early write");
  a_end_on_bus: assert property (
    status_out.done |-> $past(mem_req_out.rd || mem_req_out.wr))
    else $error("instruction ended in idle cycle");
  a_unsup_done: assert property (
    status_out.unsupported |-> status_out.done) else $error("lone flag");

  c_write: cover property ($rose(mem_req_out.wr));
  c_idle: cover property ($fell(mem_req_out.rd) && !mem_req_out.wr);
  c_unsup: cover property (status_out.unsupported);
endmodule // elg_core_props

bind elg_core elg_core_props elg_core_props_i (.clock_in(clock_in),
  .reset_in(reset_in), .mem_req_out(mem_req_out), .regs_out(regs_out),
  .status_out(status_out));

//--- verification/elg_mem_model.sv
// Behavioural memory on the far side of the core's bus
module elg_mem_model
  import elg_pkg::*;
(
  // Clock and bus
  input wire logic   clock_in,
  input elg_bus_t    req_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    last = 8'h00;
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  assign rdata_out = req_in.rd ? mem[req_in.addr] : ~last;
  always @(posedge clock_in)
  begin
    if (req_in.rd) last <= mem[req_in.addr];
    if (req_in.wr) mem[req_in.addr] <= req_in.wdata;
  end
endmodule // elg_mem_model

//--- verification/tb.sv
// Self-checking bench for the transfer group core
module tb
  import elg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clock_in = 1'b0;
  logic            reset_in = 1'b1;
  logic            ce       = 1'b1;
  logic [15:0]     idx1     = 16'h3100;
  logic [15:0]     idx2     = 16'h2a19;
  logic [7:0]      rdata;
  elg_bus_t        req;
  logic [7:0][7:0] regs;
  logic [15:0]     pc;
  elg_status_t     status;
  int              failures = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  logic [7:0]      prog [0:23] = '{8'h06, 8'h5a, 8'h48, 8'h26, 8'h21,
    8'h2e, 8'h46, 8'h70, 8'h7e, 8'h36, 8'h28, 8'hdd, 8'h71, 8'h06, 8'hfd,
    8'h5e, 8'hfc, 8'hdd, 8'h56, 8'h06, 8'hfd, 8'h77, 8'hff, 8'h76};

  elg_core elg_core_i (.clock_in(clock_in), .reset_in(reset_in),
    .ce_in(ce), .mem_rdata_in(rdata), .mem_req_out(req),
    .index_reg_first_in(idx1), .index_reg_second_in(idx2),
    .regs_out(regs), .pc_out(pc), .status_out(status));
  elg_mem_model elg_mem_model_i (.clock_in(clock_in), .req_in(req),
    .rdata_out(rdata));

  initial
  begin
    forever #2 clock_in = ~clock_in;
  end

  task automatic test_done;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts clocks up to the done pulse of one instruction
  task automatic exec(input int len, input logic unsup);
    int n;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n++;
      @(negedge clock_in);
    end
    while (status.done !== 1'b1 && n < 40);
    check(16'(n), 16'(len));
    check(16'(status.unsupported), 16'(unsup));
  endtask

  task automatic t_reg_loads;
    exec(7, 1'b0);
    check(16'(regs[0]), 16'h005a);
    exec(4, 1'b0);
    check(16'(regs[1]), 16'h005a);
    exec(7, 1'b0);
    exec(7, 1'b0);
    check({regs[4], regs[5]}, 16'h2146);
  endtask

  task automatic t_pointer;
    exec(7, 1'b0);
    check(16'(elg_mem_model_i.mem[16'h2146]), 16'h005a);
    exec(7, 1'b0);
    check(16'(regs[7]), 16'h005a);
    exec(10, 1'b0);
    check(16'(elg_mem_model_i.mem[16'h2146]), 16'h0028);
  endtask

  task automatic t_index;
    exec(19, 1'b0);
    check(16'(elg_mem_model_i.mem[16'h3106]), 16'h005a);
    exec(19, 1'b0);
    check(16'(regs[3]), 16'h0039);
    exec(19, 1'b0);
    check(16'(regs[2]), 16'h005a);
    exec(19, 1'b0);
    check(16'(elg_mem_model_i.mem[16'h2a18]), 16'h005a);
    check(pc, 16'h0017);
  endtask

  task automatic t_unsupported;
    exec(4, 1'b1);
    check(16'(regs[6]), 16'h0000);
  endtask

  // Clock enable low freezes the fetch of the trailing no-op opcode
  task automatic t_stall;
    logic [15:0] held;
    @(posedge clock_in);
    @(negedge clock_in);
    held = req.addr;
    ce   = 1'b0;
    repeat (3) @(negedge clock_in);
    check(req.addr, held);
    check(pc, 16'h0018);
    check(16'(status.done), 16'h0000);
    ce   = 1'b1;
    exec(3, 1'b1);
    check(pc, 16'h0019);
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 400)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    #1;
    foreach (prog[i]) elg_mem_model_i.mem[i] = prog[i];
    elg_mem_model_i.mem[16'h2a15] = 8'h39;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    reset_in = 1'b0;
    t_reg_loads();
    t_pointer();
    t_index();
    t_unsupported();
    t_stall();
    test_done();
  end
endmodule // tb
